// [slice_pkg.sv]
// Purpose: Shared constants and types for the instruction decode slice
// Assumes: 16-bit instruction words, 8-bit data, 21-bit byte program counter
// Notes: Field positions are bit indices within the instruction word
package slice_pkg;

    localparam int PC_W = 21;
    localparam int DADDR_W = 12;

    // Four phases of one instruction cycle
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_e;

    typedef enum logic [2:0] {
        OP_NONE, OP_TOGGLE, OP_BR_OV, OP_BR_Z,
        OP_CALL, OP_CLEAR, OP_CLEAR_WATCHDOG_OP, OP_COMP
    } op_e;

    // Opcode values, compared against the top bits of the word
    localparam logic [3:0] TOGGLE_OPC = 4'h7;
    localparam logic [7:0] BR_OV_OPC = 8'hE4;
    localparam logic [7:0] BR_Z_OPC = 8'hE0;
    localparam logic [6:0] CALL_OPC = 7'h76;
    localparam logic [3:0] CALL_WORD2_OPC = 4'hF;
    localparam logic [6:0] CLEAR_OPC = 7'h35;
    localparam logic [5:0] COMP_OPC = 6'h07;
    localparam logic [15:0] CLEAR_WATCHDOG_OP_WORD = 16'h0004;

    // Field positions
    localparam int TOP_BIT = 15;
    localparam int A_BIT = 8;
    localparam int S_BIT = 8;
    localparam int D_BIT = 9;
    localparam int BITSEL_LSB = 9;
    localparam int BITSEL_W = 3;
    localparam int FILE_W = 8;
    localparam int K_HI_W = 12;

    // Status register bit positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_N = 4;

    // Access bank layout
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;

    // Program counter steps
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W-1:0] CALL_RET_STEP = 21'h000004;

    // Reset values
    localparam logic [PC_W-1:0] PC_RST = 21'h000000;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [DADDR_W-1:0] DADDR_RST = 12'h000;
    localparam logic FLAG_N_RST = 1'b1;

endpackage

// [phase_seq.sv]
// Purpose: Generates the four internal phases of each instruction cycle
// Assumes: One phase per core clock
// Notes: Free running from reset release
`timescale 1ns/1ps
module phase_seq (
    input wire logic clk,
    input wire logic resetn,
    output slice_pkg::phase_e phase
);

    slice_pkg::phase_e phase_next;

    always_comb begin
        case (phase)
            slice_pkg::PH_Q1: phase_next = slice_pkg::PH_Q2;
            slice_pkg::PH_Q2: phase_next = slice_pkg::PH_Q3;
            slice_pkg::PH_Q3: phase_next = slice_pkg::PH_Q4;
            slice_pkg::PH_Q4: phase_next = slice_pkg::PH_Q1;
            default: phase_next = slice_pkg::PH_Q1;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase <= slice_pkg::PH_Q1;
        end else begin
            phase <= phase_next;
        end
    end

endmodule // phase_seq

// [instr_slice.sv]
// Purpose: Decode and execute for toggle, branches, call, clear, watchdog
//          clear and complement instructions
// Assumes: Program and data memory answer combinationally to the address
// Notes: Core may load status, bank and working registers via load ports
// Summary of operation
// - Bit toggle inverts one selected bit, writes back, leaves flags alone.
// - Access bit 0 uses the fixed access bank; 1 uses bank select.
// - Branch on overflow jumps only when overflow is set; flags unchanged.
// - Branch on zero jumps only when zero is set; flags unchanged.
// - Taken branch loads next address plus twice the signed offset.
// - Branch takes one cycle untaken, two when taken with idle second.
// - Call pushes current address plus four before redirecting the counter.
// - Call with shadow bit copies working, status, bank into shadows.
// - Call is two words; twenty-bit target loads counter bits 20:1.
// - Call lasts two cycles: push in Q3, target written in Q4.
// - Clear writes zero to the register and sets zero flag.
// - Watchdog clear resets counter and postscaler within one cycle.
// - Watchdog clear sets both active-low time-out and power-down bits.
// - Complement inverts the register and updates negative and zero.
// - Complement destination bit 0 writes working, 1 writes the register.
// - Register instructions: decode, read, process, write over four phases.
`timescale 1ns/1ps
module instr_slice (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] instr_word,
    output logic [20:0] prog_addr,
    output logic [11:0] dmem_addr,
    output logic dmem_rd_en,
    input wire logic [7:0] dmem_rdata,
    output logic dmem_wr_en,
    output logic [7:0] dmem_wdata,
    output logic stack_push,
    output logic [20:0] top_of_return_stack,
    output logic [7:0] status_reg,
    output logic [3:0] bank_select_reg,
    output logic [7:0] working_reg,
    output logic [7:0] flags_shadow,
    output logic [3:0] bank_shadow,
    output logic [7:0] working_shadow,
    output logic watchdog_clear,
    output logic watchdog_expiry_flag_n,
    output logic powerdown_flag_n,
    input wire logic status_load,
    input wire logic [7:0] status_wdata,
    input wire logic bank_load,
    input wire logic [3:0] bank_wdata,
    input wire logic working_load,
    input wire logic [7:0] working_wdata,
    input wire logic watchdog_timeout,
    input wire logic sleep_entry
);

    slice_pkg::phase_e phase;
    slice_pkg::op_e op;
    logic [15:0] instr_reg;
    logic [15:0] cur_word;
    logic [20:0] pc_reg;
    logic [20:0] pc_next;
    logic idle_reg;
    logic [7:0] data_reg;
    logic [7:0] result_reg;
    logic [7:0] result_next;
    logic [7:0] file_addr;
    logic [11:0] addr_next;
    logic [20:0] branch_target;
    logic taken;
    logic file_op;

    phase_seq u_phase (
        .clk(clk),
        .resetn(resetn),
        .phase(phase)
    );

    // Q1 decodes the fresh word, later phases use the latched copy
    always_comb begin
        if (phase == slice_pkg::PH_Q1) begin
            cur_word = instr_word;
        end else begin
            cur_word = instr_reg;
        end
    end

    always_comb begin
        op = slice_pkg::OP_NONE;
        if (idle_reg) begin
            op = slice_pkg::OP_NONE;
        end else if (cur_word == slice_pkg::CLEAR_WATCHDOG_OP_WORD) begin
            op = slice_pkg::OP_CLEAR_WATCHDOG_OP;
        end else if (cur_word[slice_pkg::TOP_BIT -: 4]
                     == slice_pkg::TOGGLE_OPC) begin
            op = slice_pkg::OP_TOGGLE;
        end else if (cur_word[slice_pkg::TOP_BIT -: 8]
                     == slice_pkg::BR_OV_OPC) begin
            op = slice_pkg::OP_BR_OV;
        end else if (cur_word[slice_pkg::TOP_BIT -: 8]
                     == slice_pkg::BR_Z_OPC) begin
            op = slice_pkg::OP_BR_Z;
        end else if (cur_word[slice_pkg::TOP_BIT -: 7]
                     == slice_pkg::CALL_OPC) begin
            op = slice_pkg::OP_CALL;
        end else if (cur_word[slice_pkg::TOP_BIT -: 7]
                     == slice_pkg::CLEAR_OPC) begin
            op = slice_pkg::OP_CLEAR;
        end else if (cur_word[slice_pkg::TOP_BIT -: 6]
                     == slice_pkg::COMP_OPC) begin
            op = slice_pkg::OP_COMP;
        end
    end

    assign file_op = (op == slice_pkg::OP_TOGGLE)
                     || (op == slice_pkg::OP_CLEAR)
                     || (op == slice_pkg::OP_COMP);
    assign file_addr = cur_word[slice_pkg::FILE_W-1:0];

    always_comb begin
        if (cur_word[slice_pkg::A_BIT]) begin
            addr_next = {bank_select_reg, file_addr};
        end else if (file_addr >= slice_pkg::ACCESS_SPLIT) begin
            addr_next = {slice_pkg::ACCESS_HI_BANK, file_addr};
        end else begin
            addr_next = {slice_pkg::ACCESS_LO_BANK, file_addr};
        end
    end

    assign branch_target = pc_reg + slice_pkg::PC_STEP
        + {{12{instr_reg[7]}}, instr_reg[7:0], 1'b0};

    assign taken = ((op == slice_pkg::OP_BR_OV)
                    && status_reg[slice_pkg::ST_OV])
                   || ((op == slice_pkg::OP_BR_Z)
                    && status_reg[slice_pkg::ST_Z]);

    always_comb begin
        case (op)
            slice_pkg::OP_TOGGLE: result_next = data_reg
                ^ (8'h01 << instr_reg[slice_pkg::BITSEL_LSB +:
                                      slice_pkg::BITSEL_W]);
            slice_pkg::OP_COMP: result_next = ~data_reg;
            default: result_next = slice_pkg::BYTE_RST;
        endcase
    end

    always_comb begin
        if (idle_reg) begin
            pc_next = pc_reg;
        end else if (op == slice_pkg::OP_CALL) begin
            pc_next = {instr_word[slice_pkg::K_HI_W-1:0],
                       instr_reg[7:0], 1'b0};
        end else if (taken) begin
            pc_next = branch_target;
        end else begin
            pc_next = pc_reg + slice_pkg::PC_STEP;
        end
    end

    // latch word at end of decode
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            instr_reg <= slice_pkg::WORD_RST;
        end else if (phase == slice_pkg::PH_Q1) begin
            instr_reg <= instr_word;
        end
    end

    // counter, fetch address and idle cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc_reg <= slice_pkg::PC_RST;
            prog_addr <= slice_pkg::PC_RST;
            idle_reg <= 1'b0;
        end else if (phase == slice_pkg::PH_Q1
                     && op == slice_pkg::OP_CALL) begin
            prog_addr <= pc_reg + slice_pkg::PC_STEP;
        end else if (phase == slice_pkg::PH_Q4) begin
            pc_reg <= pc_next;
            prog_addr <= pc_next;
            idle_reg <= !idle_reg && (taken || op == slice_pkg::OP_CALL);
        end
    end

    // read strobe during Q2, data taken at its end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dmem_addr <= slice_pkg::DADDR_RST;
            dmem_rd_en <= 1'b0;
            data_reg <= slice_pkg::BYTE_RST;
        end else begin
            dmem_rd_en <= (phase == slice_pkg::PH_Q1) && file_op;
            if (phase == slice_pkg::PH_Q1 && file_op) begin
                dmem_addr <= addr_next;
            end
            if (dmem_rd_en) begin
                data_reg <= dmem_rdata;
            end
        end
    end

    // write strobe during Q4 unless result goes to working
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            result_reg <= slice_pkg::BYTE_RST;
            dmem_wr_en <= 1'b0;
            dmem_wdata <= slice_pkg::BYTE_RST;
        end else begin
            dmem_wr_en <= (phase == slice_pkg::PH_Q3) && file_op
                && !(op == slice_pkg::OP_COMP
                     && !instr_reg[slice_pkg::D_BIT]);
            if (phase == slice_pkg::PH_Q3) begin
                result_reg <= result_next;
                dmem_wdata <= result_next;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stack_push <= 1'b0;
            top_of_return_stack <= slice_pkg::PC_RST;
        end else begin
            stack_push <= (phase == slice_pkg::PH_Q2)
                          && (op == slice_pkg::OP_CALL);
            if (phase == slice_pkg::PH_Q2 && op == slice_pkg::OP_CALL) begin
                top_of_return_stack <= pc_reg + slice_pkg::CALL_RET_STEP;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_shadow <= slice_pkg::STATUS_RST;
            bank_shadow <= slice_pkg::BANK_RST;
            working_shadow <= slice_pkg::BYTE_RST;
        end else if (phase == slice_pkg::PH_Q3 && op == slice_pkg::OP_CALL
                     && instr_reg[slice_pkg::S_BIT]) begin
            flags_shadow <= status_reg;
            bank_shadow <= bank_select_reg;
            working_shadow <= working_reg;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_reg <= slice_pkg::STATUS_RST;
        end else if (phase == slice_pkg::PH_Q4
                     && op == slice_pkg::OP_CLEAR) begin
            status_reg[slice_pkg::ST_Z] <= 1'b1;
        end else if (phase == slice_pkg::PH_Q4
                     && op == slice_pkg::OP_COMP) begin
            status_reg[slice_pkg::ST_Z] <= (result_reg == 8'h00);
            status_reg[slice_pkg::ST_N] <= result_reg[7];
        end else if (status_load) begin
            status_reg <= status_wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bank_select_reg <= slice_pkg::BANK_RST;
        end else if (bank_load) begin
            bank_select_reg <= bank_wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            working_reg <= slice_pkg::BYTE_RST;
        end else if (phase == slice_pkg::PH_Q4 && op == slice_pkg::OP_COMP
                     && !instr_reg[slice_pkg::D_BIT]) begin
            working_reg <= result_reg;
        end else if (working_load) begin
            working_reg <= working_wdata;
        end
    end

    // watchdog clear; instruction wins over same-cycle events
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            watchdog_clear <= 1'b0;
            watchdog_expiry_flag_n <= slice_pkg::FLAG_N_RST;
            powerdown_flag_n <= slice_pkg::FLAG_N_RST;
        end else begin
            watchdog_clear <= (phase == slice_pkg::PH_Q3)
                              && (op == slice_pkg::OP_CLEAR_WATCHDOG_OP);
            if (phase == slice_pkg::PH_Q3 && op == slice_pkg::OP_CLEAR_WATCHDOG_OP) begin
                watchdog_expiry_flag_n <= 1'b1;
                powerdown_flag_n <= 1'b1;
            end else begin
                if (watchdog_timeout) begin
                    watchdog_expiry_flag_n <= 1'b0;
                end
                if (sleep_entry) begin
                    powerdown_flag_n <= 1'b0;
                end
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence call_q2_s;
        phase == slice_pkg::PH_Q2 && op == slice_pkg::OP_CALL;
    endsequence

    sequence push_then_drop_s;
        stack_push && top_of_return_stack == $past(pc_reg)
            + slice_pkg::CALL_RET_STEP ##1 !stack_push;
    endsequence

    toggle_one_bit_a: assert property (
        phase == slice_pkg::PH_Q4 && op == slice_pkg::OP_TOGGLE
        |-> dmem_wr_en && $countones(dmem_wdata ^ data_reg) == 1)
        else $error("toggle did not flip exactly one bit");

    bank_select_a: assert property (
        phase == slice_pkg::PH_Q1 && file_op && cur_word[slice_pkg::A_BIT]
        |=> dmem_rd_en && dmem_addr[11:8] == $past(bank_select_reg))
        else $error("bank select not used for read address");

    branch_flags_a: assert property (
        phase == slice_pkg::PH_Q4 && !status_load
        && (op == slice_pkg::OP_BR_OV || op == slice_pkg::OP_BR_Z)
        |=> $stable(status_reg))
        else $error("branch changed the flags");

    // taken branch target and idle cycle
    branch_taken_a: assert property (
        phase == slice_pkg::PH_Q4 && taken
        |=> pc_reg == $past(branch_target) ##0 idle_reg[*4] ##1 !idle_reg)
        else $error("taken branch target or idle cycle wrong");

    branch_untaken_a: assert property (
        phase == slice_pkg::PH_Q4 && !taken
        && (op == slice_pkg::OP_BR_OV || op == slice_pkg::OP_BR_Z)
        |=> pc_reg == $past(pc_reg) + slice_pkg::PC_STEP && !idle_reg)
        else $error("untaken branch did not just advance");

    call_push_a: assert property (
        call_q2_s |=> push_then_drop_s)
        else $error("call push wrong");

    call_no_shadow_a: assert property (
        phase == slice_pkg::PH_Q3 && op == slice_pkg::OP_CALL
        && !instr_reg[slice_pkg::S_BIT]
        |=> $stable(flags_shadow) && $stable(working_shadow))
        else $error("shadow changed without shadow bit");

    // call target and idle second cycle
    call_target_a: assert property (
        phase == slice_pkg::PH_Q4 && op == slice_pkg::OP_CALL
        |=> pc_reg == {$past(instr_word[11:0]), $past(instr_reg[7:0]),
                       1'b0} && idle_reg)
        else $error("call target wrong");

    // clear writes zero and sets zero flag
    clear_write_a: assert property (
        phase == slice_pkg::PH_Q3 && op == slice_pkg::OP_CLEAR
        |=> dmem_wr_en && dmem_wdata == 8'h00
        ##1 status_reg[slice_pkg::ST_Z])
        else $error("clear did not zero register and set zero");

    wdt_clear_a: assert property (
        phase == slice_pkg::PH_Q3 && op == slice_pkg::OP_CLEAR_WATCHDOG_OP
        |=> watchdog_clear && watchdog_expiry_flag_n && powerdown_flag_n
        ##1 !watchdog_clear)
        else $error("watchdog clear effects wrong");

    // complement to working leaves memory alone
    comp_dest_a: assert property (
        phase == slice_pkg::PH_Q4 && op == slice_pkg::OP_COMP
        && !instr_reg[slice_pkg::D_BIT] && !working_load
        |-> !dmem_wr_en ##1 working_reg == ~data_reg)
        else $error("complement destination wrong");

endmodule // instr_slice

// [slice_mem_model.sv]
// Purpose: Program memory and banked data memory beside the slice
// Assumes: Both memories answer combinationally to their addresses
// Notes: Unset program words read as 0000; idle read data is inverted
`timescale 1ns/1ps
module slice_mem_model (
    input wire logic clk,
    input wire logic [20:0] prog_addr,
    output logic [15:0] instr_word,
    input wire logic [11:0] dmem_addr,
    input wire logic dmem_rd_en,
    output logic [7:0] dmem_rdata,
    input wire logic dmem_wr_en,
    input wire logic [7:0] dmem_wdata
);
    logic [15:0] pmem [int];
    logic [7:0] dmem [0:4095];
    logic [7:0] last_rd;
    int gen;

    initial begin
        gen = 0;
        last_rd = 8'h00;
        foreach (dmem[i]) begin
            dmem[i] = 8'h00;
        end
    end

    task automatic put(input int a, input logic [15:0] w);
        pmem[a >> 1] = w;
        gen++;
    endtask

    task automatic wipe();
        pmem.delete();
        gen++;
    endtask

    // Gen read so the lookup re-runs after every load
    always_comb begin
        if (gen >= 0 && pmem.exists(int'(prog_addr[20:1]))) begin
            instr_word = pmem[int'(prog_addr[20:1])];
        end else begin
            instr_word = 16'h0000;
        end
    end

    // Released data lines never repeat the last byte
    assign dmem_rdata = dmem_rd_en ? dmem[dmem_addr] : ~last_rd;

    always @(posedge clk) begin
        if (dmem_rd_en) begin
            last_rd <= dmem[dmem_addr];
        end
        if (dmem_wr_en) begin
            dmem[dmem_addr] <= dmem_wdata;
        end
    end
endmodule // slice_mem_model

// [cpu_instr_decode_exec_slice_tb.sv]
// Purpose: Self-checking bench for the instruction decode slice
// Assumes: Each run starts with a no-op at address 0
// Notes: Instruction i at address 2i ends its Q4 at edge 4i+4
`timescale 1ns/1ps
module cpu_instr_decode_exec_slice_tb;
    logic clk, resetn, dmem_rd_en, dmem_wr_en, stack_push, watchdog_clear;
    logic watchdog_expiry_flag_n, powerdown_flag_n, status_load, bank_load;
    logic working_load, watchdog_timeout, sleep_entry;
    logic [15:0] instr_word;
    logic [20:0] prog_addr, top_of_return_stack;
    logic [11:0] dmem_addr;
    logic [7:0] dmem_rdata, dmem_wdata, status_reg, working_reg, flags_shadow;
    logic [7:0] working_shadow, status_wdata, working_wdata;
    logic [3:0] bank_select_reg, bank_shadow, bank_wdata;
    int fails, num_checks;

    instr_slice instr_slice_i (.clk(clk), .resetn(resetn),
        .instr_word(instr_word), .prog_addr(prog_addr),
        .dmem_addr(dmem_addr), .dmem_rd_en(dmem_rd_en),
        .dmem_rdata(dmem_rdata), .dmem_wr_en(dmem_wr_en),
        .dmem_wdata(dmem_wdata), .stack_push(stack_push),
        .top_of_return_stack(top_of_return_stack), .status_reg(status_reg),
        .bank_select_reg(bank_select_reg), .working_reg(working_reg),
        .flags_shadow(flags_shadow), .bank_shadow(bank_shadow),
        .working_shadow(working_shadow), .watchdog_clear(watchdog_clear),
        .watchdog_expiry_flag_n(watchdog_expiry_flag_n),
        .powerdown_flag_n(powerdown_flag_n), .status_load(status_load),
        .status_wdata(status_wdata), .bank_load(bank_load),
        .bank_wdata(bank_wdata), .working_load(working_load),
        .working_wdata(working_wdata), .watchdog_timeout(watchdog_timeout),
        .sleep_entry(sleep_entry));

    slice_mem_model mem_i (.clk(clk), .prog_addr(prog_addr),
        .instr_word(instr_word), .dmem_addr(dmem_addr),
        .dmem_rd_en(dmem_rd_en), .dmem_rdata(dmem_rdata),
        .dmem_wr_en(dmem_wr_en), .dmem_wdata(dmem_wdata));

    always #2 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic ed(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic rst();
        resetn = 1'b0;
        {status_load, bank_load, working_load} = 3'h0;
        {watchdog_timeout, sleep_entry} = 2'h0;
        {status_wdata, working_wdata, bank_wdata} = 20'h00000;
        mem_i.wipe();
        ed(10);
    endtask

    // Release, then load the core registers at edge 1
    task automatic go(input logic [7:0] st, input logic [3:0] bk,
            input logic [7:0] wk);
        resetn = 1'b1;
        {status_load, bank_load, working_load} = 3'h7;
        status_wdata = st;
        bank_wdata = bk;
        working_wdata = wk;
        ed(1);
        {status_load, bank_load, working_load} = 3'h0;
        {watchdog_timeout, sleep_entry} = 2'h0;
    endtask

    task automatic t_toggle();
        rst();
        mem_i.put(2, 16'h7885);
        mem_i.put(4, 16'h7310);
        mem_i.dmem[12'hF85] = 8'h75;
        mem_i.dmem[12'h310] = 8'h00;
        go(8'h1F, 4'h3, 8'h00);
        ed(4);
        chk(dmem_addr, 12'hF85);
        chk(dmem_rd_en, 1'b1);
        ed(2);
        chk({dmem_wr_en, dmem_wdata}, 9'h165);
        ed(2);
        chk(mem_i.dmem[12'hF85], 8'h65);
        ed(4);
        chk(mem_i.dmem[12'h310], 8'h02);
        chk(bank_select_reg, 4'h3);
        chk(status_reg, 8'h1F);
    endtask

    task automatic t_data();
        rst();
        mem_i.put(2, 16'h6B40);
        mem_i.put(4, 16'h1D41);
        mem_i.put(6, 16'h1E20);
        mem_i.dmem[12'h240] = 8'h5A;
        mem_i.dmem[12'h241] = 8'h13;
        mem_i.dmem[12'h020] = 8'hFF;
        go(8'h00, 4'h2, 8'h00);
        ed(8);
        chk(mem_i.dmem[12'h240], 8'h00);
        chk(status_reg[2], 1'b1);
        ed(4);
        chk(working_reg, 8'hEC);
        chk(mem_i.dmem[12'h241], 8'h13);
        chk({status_reg[4], status_reg[2]}, 2'h2);
        ed(4);
        chk(mem_i.dmem[12'h020], 8'h00);
        chk({status_reg[4], status_reg[2]}, 2'h1);
    endtask

    task automatic t_branch();
        rst();
        mem_i.put(2, 16'hE433);
        mem_i.put(4, 16'hE005);
        mem_i.put(16, 16'hE4F8);
        go(8'h04, 4'h0, 8'h00);
        ed(7);
        chk(prog_addr, 21'h000004);
        ed(4);
        chk(prog_addr, 21'h000010);
        chk(status_reg, 8'h04);
        status_load = 1'b1;
        status_wdata = 8'h0C;
        ed(1);
        status_load = 1'b0;
        ed(3);
        chk(prog_addr, 21'h000010);
        ed(4);
        chk(prog_addr, 21'h000002);
        chk(status_reg, 8'h0C);
    endtask

    task automatic t_call();
        rst();
        mem_i.put(2, 16'hED45);
        mem_i.put(4, 16'hF123);
        mem_i.put(32'h2468A, 16'hEC10);
        mem_i.put(32'h2468C, 16'hF000);
        go(8'h05, 4'h6, 8'hA5);
        ed(5);
        chk(stack_push, 1'b1);
        ed(1);
        chk(top_of_return_stack, 21'h000006);
        ed(1);
        chk(prog_addr, 21'h02468A);
        chk({flags_shadow, bank_shadow, working_shadow}, 20'h056A5);
        working_load = 1'b1;
        working_wdata = 8'h3C;
        ed(1);
        working_load = 1'b0;
        ed(3);
        chk(prog_addr, 21'h02468A);
        ed(4);
        chk(prog_addr, 21'h000020);
        chk(top_of_return_stack, 21'h02468E);
        chk({working_reg, working_shadow}, 16'h3CA5);
    endtask

    task automatic t_wdt();
        rst();
        mem_i.put(2, 16'h0004);
        watchdog_timeout = 1'b1;
        sleep_entry = 1'b1;
        go(8'h00, 4'h0, 8'h00);
        chk({watchdog_expiry_flag_n, powerdown_flag_n}, 2'h0);
        ed(6);
        chk(watchdog_clear, 1'b1);
        ed(1);
        chk({watchdog_expiry_flag_n, powerdown_flag_n}, 2'h3);
        chk(watchdog_clear, 1'b0);
    endtask

    task automatic print_verdict();
        if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        fails = 0;
        num_checks = 0;
        t_toggle();
        t_data();
        t_branch();
        t_call();
        t_wdt();
        print_verdict();
    end
endmodule // cpu_instr_decode_exec_slice_tb
